/* sgwl_loader.sv */
// Serial gain word loader: shift register on the link clock, gain latch on mclk
`timescale 1ns/10ps
module sgwl_loader
   import sgwl_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic serial_clk,
   input wire logic load_enable_n,
   input wire logic serial_gain_in,
   input wire logic transmit_power_on,
   input wire logic sleep_n,
   output logic [6:0] gain_code,
   output logic gain_update,
   output logic tx_powered,
   output logic output_enable
);
   // ==========================================
   // Link side
   // Reset for the link domain is the mclk reset carried over; the serial
   // clock only runs in frames, so the shifter simply holds its state idle.
   logic link_rst_meta_reg;
   logic link_rst_reg;
   logic master_reg;
   logic [6:0] slave_reg;
   logic [6:0] slave_next;
   logic shift_en;

   always_ff @(posedge serial_clk)
   begin
      link_rst_meta_reg <= reset;
      link_rst_reg <= link_rst_meta_reg;
   end

   // Load enable is sampled by the device on the serial clock, its setup honoured by the host
   assign shift_en = ~load_enable_n; // RQ1 RQ2
   // Oldest bit drops off the top after seven more clocks, so bit 7 is lost
   assign slave_next = {slave_reg[5:0], master_reg}; // RQ3 RQ4 RQ10

   always_ff @(posedge serial_clk)
   begin
      if (link_rst_reg)
         master_reg <= 1'b0;
      else if (shift_en)
         master_reg <= serial_gain_in; // RQ5 RQ7
   end

   always_ff @(negedge serial_clk)
   begin
      if (link_rst_reg)
         slave_reg <= SGWL_SHIFT_RESET;
      else if (shift_en)
         slave_reg <= slave_next; // RQ6
   end

   // ==========================================
   // Crossing to mclk
   // The slave word is stable while load enable is high, so it is safe to
   // capture after the synchronised rising edge of load enable.
   logic load_meta_reg;
   logic load_sync_reg;
   logic load_sync;
   logic load_prev_reg;
   logic load_rise;
   logic [6:0] gain_reg;
   logic update_reg;
   logic transmit_power_on_sync;
   logic sleep_sync;

   // Load enable gets its own synchroniser that resets to the pin's idle
   // level; a shared one resetting low would fake a load edge after reset
   // and copy an unshifted word into the gain latch.
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         load_meta_reg <= 1'b1;
         load_sync_reg <= 1'b1;
      end
      else
      begin
         load_meta_reg <= load_enable_n;
         load_sync_reg <= load_meta_reg;
      end
   end

   assign load_sync = load_sync_reg;

   sgwl_sync u_transmit_power_on (.clk(mclk), .reset(reset), .din(transmit_power_on), .dout(transmit_power_on_sync));
   sgwl_sync u_sleep (.clk(mclk), .reset(reset), .din(sleep_n), .dout(sleep_sync));

   assign load_rise = load_sync & ~load_prev_reg; // RQ1

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         load_prev_reg <= 1'b1;
         gain_reg <= SGWL_GAIN_RESET;
         update_reg <= 1'b0;
      end
      else
      begin
         load_prev_reg <= load_sync;
         update_reg <= load_rise;
         if (load_rise)
            gain_reg <= slave_reg; // RQ1 RQ11
      end
   end

   // ==========================================
   // Power control
   assign gain_code = gain_reg; // RQ2 RQ11
   assign gain_update = update_reg;
   assign tx_powered = transmit_power_on_sync & sleep_sync; // RQ8 RQ9
   assign output_enable = sleep_sync; // RQ9

   // ==========================================
   // Checks
   sequence load_edge_s;
      $rose(load_sync);
   endsequence

   property latch_load_p;
      @(posedge mclk) disable iff (reset)
      load_edge_s |=> (gain_code == $past(slave_reg)) && gain_update;
   endproperty
   latch_load_a: assert property (latch_load_p) else $error("gain not loaded"); // RQ1

   gain_hold_a: assert property (@(posedge mclk) disable iff (reset)
      !load_rise |=> $stable(gain_code)) else $error("gain moved"); // RQ2 RQ11

   shift_order_a: assert property (@(negedge serial_clk) disable iff (link_rst_reg)
      shift_en |=> slave_reg[0] == $past(master_reg)) else $error("bad shift"); // RQ3 RQ6

   shift_drop_a: assert property (@(negedge serial_clk) disable iff (link_rst_reg)
      shift_en |=> slave_reg[6:1] == $past(slave_reg[5:0])) else $error("bad drop"); // RQ4 RQ10

   master_cap_a: assert property (@(posedge serial_clk) disable iff (link_rst_reg)
      shift_en |=> master_reg == $past(serial_gain_in)) else $error("bad capture"); // RQ5

   shift_stop_a: assert property (@(negedge serial_clk) disable iff (link_rst_reg)
      !shift_en |=> $stable(slave_reg)) else $error("shifted when off"); // RQ1

   tx_power_a: assert property (@(posedge mclk) disable iff (reset)
      tx_powered |-> transmit_power_on_sync && sleep_sync) else $error("bad power"); // RQ8

   sleep_out_a: assert property (@(posedge mclk) disable iff (reset)
      !sleep_sync |-> !output_enable && !tx_powered) else $error("sleep drive"); // RQ9

   // ==========================================
   // Pulse and latch bookkeeping
   sequence update_s;
      gain_update;
   endsequence

   update_once_a: assert property (@(posedge mclk) disable iff (reset)
      update_s |=> !gain_update) else $error("update too long"); // RQ1

   update_cause_a: assert property (@(posedge mclk) disable iff (reset)
      update_s |-> $past(load_rise)) else $error("update without load"); // RQ1

   // A gain change that no load edge explains means the latch leaked
   gain_cause_a: assert property (@(posedge mclk) disable iff (reset)
      $changed(gain_code) |-> gain_update) else $error("gain changed alone"); // RQ11

   sleep_wake_a: assert property (@(posedge mclk) disable iff (reset)
      sleep_sync |-> output_enable) else $error("output not driven"); // RQ9

   transmit_power_on_off_a: assert property (@(posedge mclk) disable iff (reset)
      !transmit_power_on_sync |-> !tx_powered) else $error("powered while off"); // RQ8

   master_hold_a: assert property (@(posedge serial_clk) disable iff (link_rst_reg)
      !shift_en |=> $stable(master_reg)) else $error("captured when off"); // RQ1
endmodule

/* sgwl_pkg.sv */
// Constants for the serial gain word loader
// Notes on behaviour
// (RQ1) Load enable rising edge copies shifted word to gain latch and stops shifting.
// (RQ2) Load enable falling edge freezes gain latch and enables serial shifting.
// (RQ3) Eight-bit gain word arrives most significant bit first and shifts in order.
// (RQ4) The most significant bit of the gain word never affects gain.
// (RQ5) Serial clock rising edge captures the data bit into the master stage.
// (RQ6) Serial clock falling edge passes the master bit to the slave stage.
// (RQ7) Host holds each data bit valid by the capturing rising clock edge.
// (RQ8) Transmit power on at logic 1 powers the device up for transmission.
// (RQ9) Sleep low powers down and tristates output; sleep high powers up.
// (RQ10) Register holds seven bits; first bit falls out on the eighth clock.
// (RQ11) Gain latch keeps its value in sleep or transmit off; changes only on load.
package sgwl_pkg;
   localparam int SGWL_WORD_BITS = 8;
   localparam int SGWL_REG_BITS = 7;
   localparam logic [6:0] SGWL_GAIN_RESET = 7'h00;
   localparam logic [6:0] SGWL_SHIFT_RESET = 7'h00;
endpackage

/* sgwl_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/10ps
module sgwl_sync
(
   input wire logic clk,
   input wire logic reset,
   input wire logic din,
   output logic dout
);
   logic meta_reg;
   logic sync_reg;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end
   assign dout = sync_reg;
endmodule

/* sgwl_host.sv */
// Host model for the loader lines
`timescale 1ns/10ps
module sgwl_host
(
   output logic serial_clk = 1'b0,
   output logic load_enable_n = 1'b1,
   output logic serial_gain_in = 1'b0
);
   // Clock idles between frames; data inverts when released
   task automatic frame(input logic [15:0] w, input int n, input logic le);
      load_enable_n = le;
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_gain_in = w[i];
         #16 serial_clk = 1'b1;
         #16 serial_clk = 1'b0;
      end
      #16 load_enable_n = 1'b1;
      serial_gain_in = ~serial_gain_in;
   endtask
endmodule

/* test_serial_gain_word_loader.sv */
// Self-checking bench
`timescale 1ns/10ps
module test_serial_gain_word_loader;
   logic mclk = 1'b0, reset = 1'b1, transmit_power_on = 1'b0, sleep_n = 1'b1;
   logic serial_clk, load_enable_n, serial_gain_in, gain_update, tx_powered, output_enable;
   logic [6:0] gain_code;
   int miscompares = 0, compares = 0, seed = 80944, sh = 0, k;
   always #25 mclk = ~mclk;
   sgwl_host u_host (.serial_clk(serial_clk), .load_enable_n(load_enable_n),
      .serial_gain_in(serial_gain_in));
   sgwl_loader u_dut (.mclk(mclk), .reset(reset), .serial_clk(serial_clk),
      .load_enable_n(load_enable_n), .serial_gain_in(serial_gain_in), .sleep_n(sleep_n),
      .transmit_power_on(transmit_power_on), .gain_code(gain_code), .gain_update(gain_update),
      .tx_powered(tx_powered), .output_enable(output_enable));
   task automatic check(input logic [6:0] seen, input logic [6:0] expv);
      compares++;
      miscompares += 32'(seen !== expv);
      if (seen !== expv)
         $display("ERROR %0t got %h exp %h", $time, seen, expv);
   endtask
   task automatic end_sim();
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask
   task automatic load(input int word, input int bits);
      u_host.frame(16'(word), bits, 1'b0);
      check(gain_code, 7'(sh));
      sh = ((sh << bits) | (word & ((1 << bits) - 1))) & 127;
      for (k = 0; k < 20 && gain_update !== 1'b1; k++)
         step(1);
      check(gain_code, 7'(sh));
      step(1);
      check(7'(gain_update), 7'h00);
      miscompares += 32'(k == 20);
      if (k == 20)
         end_sim();
      step(4);
   endtask
   initial
   begin
      u_host.frame(16'h0000, 3, 1'b1);
      step(3);
      reset = 1'b0;
      // Link reset only clears on serial clock edges, so idle clocks come first
      u_host.frame(16'h0000, 3, 1'b1);
      step(3);
      check(gain_code, 7'h00);
      for (int i = 0; i < 10; i++)
         load((i == 0) ? 255 : $random(seed), (i == 3) ? 3 : (i == 5) ? 9 : 8);
      u_host.frame(16'h00aa, 8, 1'b1);
      step(8);
      check(gain_code, 7'(sh));
      for (int p = 0; p < 4; p++)
      begin
         {transmit_power_on, sleep_n} = 2'(p);
         step(3);
         check(7'(tx_powered), 7'(p == 3));
         check(7'(output_enable), 7'(p & 1));
         check(gain_code, 7'(sh));
      end
      end_sim();
   end
endmodule
